// >>> hdl/region_map_pkg.sv
/*
  Address map constants and target codes for the system bus region decoder.
  Assumes 32-bit byte addresses on the system bus.
*/
package region_map_pkg;

  localparam int unsigned ADDR_W = 32;  // System bus address width

  // Core-internal region, served to the CPU complex only
  localparam logic [31:0] CORE_INT_LO    = 32'h0000_0000;
  localparam logic [31:0] CORE_INT_HI    = 32'h01ff_ffff;
  // Tightly coupled RAM
  localparam logic [31:0] TIGHTLY_COUPLED_RAM_LO       = 32'h0000_0000;
  localparam logic [31:0] TIGHTLY_COUPLED_RAM_HI       = 32'h0000_ffff;
  // Small-sector flash, eight sectors of 8 KByte, coupled base and mirror base
  localparam logic [31:0] SMALL_TC_LO    = 32'h009f_0000;
  localparam logic [31:0] SMALL_AXI_LO   = 32'h019f_0000;
  localparam logic [31:0] SMALL_SECT_BYT = 32'h0000_2000;
  localparam int unsigned SMALL_SECT_NUM = 8;
  // Program flash code array, coupled window and mirror window
  localparam logic [31:0] CODE_TC_LO     = 32'h00a0_0000;
  localparam logic [31:0] CODE_AXI_LO    = 32'h01a0_0000;
  localparam logic [31:0] CODE_BYTES_DEF = 32'h0040_0000;  // 4 MByte
  // System SRAM
  localparam logic [31:0] SRAM_LO        = 32'h0200_0000;
  localparam logic [31:0] SRAM_BYTES_DEF = 32'h0004_0000;  // 256 KByte
  // Core slave window into the core-internal region
  localparam logic [31:0] CORE_WIN_LO    = 32'h0280_0000;
  localparam logic [31:0] CORE_WIN_HI    = 32'h0280_002f;
  // Work flash, 112 KByte, three mirror areas
  localparam logic [31:0] WFL_BYTES      = 32'h0001_c000;
  localparam logic [31:0] WFL_A1_LO      = 32'h0e00_0000;
  localparam logic [31:0] WFL_A1_HI      = 32'h0e01_bfff;
  localparam logic [31:0] WFL_A3_LO      = 32'h0e20_0000;
  localparam logic [31:0] WFL_A3_HI      = 32'h0e21_bfff;
  localparam logic [31:0] WFL_A4_LO      = 32'h0e30_0000;
  localparam logic [31:0] WFL_A4_HI      = 32'h0e31_bfff;
  // Backup RAM, 64 KByte
  localparam logic [31:0] BURAM_LO       = 32'h0e80_0000;
  localparam logic [31:0] BURAM_HI       = 32'h0e80_ffff;
  // Peripheral area and the extra peripheral block inside it
  localparam logic [31:0] PERI_LO        = 32'hb000_0000;
  localparam logic [31:0] PERI_HI        = 32'hb7ff_ffff;
  localparam logic [31:0] XPERI_LO       = 32'hb484_0000;
  localparam logic [31:0] XPERI_HI       = 32'hb484_ffff;
  // Boot ROM and error configuration area
  localparam logic [31:0] BOOT_LO        = 32'hffff_0000;
  localparam logic [31:0] BOOT_HI        = 32'hffff_3fff;
  localparam logic [31:0] ERROR_CONFIG_AREA_LO      = 32'hffff_e000;
  localparam logic [31:0] ERROR_CONFIG_AREA_HI      = 32'hffff_ffff;

  localparam logic [31:0] OFFSET_RST     = 32'h0000_0000;  // Offset after reset

  // Decoded target of an access
  typedef enum logic [3:0] {
    TGT_NONE, TGT_TIGHTLY_COUPLED_RAM, TGT_PFLASH_SMALL, TGT_PFLASH_CODE, TGT_SRAM,
    TGT_CORE_WIN, TGT_WFLASH, TGT_BURAM, TGT_PERI, TGT_EXTRA_PERI,
    TGT_ERROR_CONFIG_AREA, TGT_BOOTROM
  } target_t;

endpackage : region_map_pkg

// >>> hdl/system_address_region_decoder.sv
/*
  System bus address decoder: routes each request to one target and gives the
  physical offset inside it, an ECC-generation qualifier and a write strobe,
  or a bus error that leaves memory untouched.
  Assumes requests are synchronous to clk and that isCpu marks the CPU complex.
  // Behaviour
  // - Core-internal region serves the CPU only
  // - Every master reaches it via the core slave window
  // - Coupled and mirror code windows share one array
  // - Small-sector windows share the same eight sectors
  // - Work flash appears as mirror area one
  // - Work flash appears again as mirror area three
  // - Work flash appears again as mirror area four
  // - Four-megabyte mirror window onto the code array
  // - Area one writes generate ECC
  // - Area three writes skip ECC generation
  // - Area four is the work flash read path
*/
`timescale 1ns/100ps
module system_address_region_decoder #(
  parameter logic [31:0] CODE_BYTES = region_map_pkg::CODE_BYTES_DEF,  // Code array size
  parameter logic [31:0] SRAM_BYTES = region_map_pkg::SRAM_BYTES_DEF   // System SRAM size
) (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic                    reqValid,
  output      logic                    reqReady,
  input  wire logic [31:0]             reqAddr,
  input  wire logic                    reqWrite,
  input  wire logic                    isCpu,
  output      logic                    respValid,
  output      region_map_pkg::target_t respTarget,
  output      logic [31:0]             respOffset,
  output      logic                    respEccGen,
  output      logic                    respWrEn,
  output      logic                    respError
);
  import region_map_pkg::*;

  // Refuse sizes that would run past the core-internal region or into the window
  if (CODE_BYTES == 32'h0 || CODE_BYTES > CODE_BYTES_DEF) begin : g_bad_code
    $error("CODE_BYTES must lie between 1 and 4 MByte");
  end
  if (SRAM_BYTES == 32'h0 || SRAM_BYTES > (CORE_WIN_LO - SRAM_LO)) begin : g_bad_sram
    $error("SRAM_BYTES overlaps the core slave window");
  end

  // Window ends derived from sizes
  localparam logic [31:0] SMALL_SPAN = SMALL_SECT_BYT * SMALL_SECT_NUM;
  localparam logic [31:0] SMALL_TC_HI  = SMALL_TC_LO + SMALL_SPAN - 32'h1;
  localparam logic [31:0] SMALL_AXI_HI = SMALL_AXI_LO + SMALL_SPAN - 32'h1;
  localparam logic [31:0] CODE_TC_HI   = CODE_TC_LO + CODE_BYTES - 32'h1;
  localparam logic [31:0] CODE_AXI_HI  = CODE_AXI_LO + CODE_BYTES - 32'h1;
  localparam logic [31:0] SRAM_HI      = SRAM_LO + SRAM_BYTES - 32'h1;

  // Whole state of the block
  typedef struct packed {
    logic        valid;   // Answer pending this cycle
    target_t     target;  // Selected target
    logic [31:0] offset;  // Physical offset within target
    logic        eccGen;  // Write carries generated ECC
    logic        wrEn;    // Write reaches memory
    logic        error;   // Bus error answer
  } state_t;

  state_t stateFf;   // Registered state
  state_t nxtState;  // Next state

  // Inclusive address range test
  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // Decode one request into the next state
  always_comb begin
    nxtState        = stateFf;
    nxtState.valid  = 1'b0;
    if (reqValid) begin
      nxtState.valid  = 1'b1;
      nxtState.target = TGT_NONE;
      nxtState.offset = OFFSET_RST;
      nxtState.eccGen = 1'b0;
      nxtState.error  = 1'b0;
      if (inRange(reqAddr, CORE_INT_LO, CORE_INT_HI)) begin
        // Core-internal region
        if (!isCpu) begin
          nxtState.error = 1'b1;
        end else if (inRange(reqAddr, TIGHTLY_COUPLED_RAM_LO, TIGHTLY_COUPLED_RAM_HI)) begin
          nxtState.target = TGT_TIGHTLY_COUPLED_RAM;
          nxtState.offset = reqAddr - TIGHTLY_COUPLED_RAM_LO;
        end else if (inRange(reqAddr, SMALL_TC_LO, SMALL_TC_HI)) begin
          // Coupled small-sector window is read-only
          nxtState.target = TGT_PFLASH_SMALL;
          nxtState.offset = reqAddr - SMALL_TC_LO;
          nxtState.error  = reqWrite;
        end else if (inRange(reqAddr, SMALL_AXI_LO, SMALL_AXI_HI)) begin
          nxtState.target = TGT_PFLASH_SMALL;
          nxtState.offset = reqAddr - SMALL_AXI_LO;
        end else if (inRange(reqAddr, CODE_TC_LO, CODE_TC_HI)) begin
          // Coupled code window is read-only
          nxtState.target = TGT_PFLASH_CODE;
          nxtState.offset = reqAddr - CODE_TC_LO;
          nxtState.error  = reqWrite;
        end else if (inRange(reqAddr, CODE_AXI_LO, CODE_AXI_HI)) begin
          nxtState.target = TGT_PFLASH_CODE;
          nxtState.offset = reqAddr - CODE_AXI_LO;
        end else begin
          nxtState.error = 1'b1;
        end
      end else if (inRange(reqAddr, SRAM_LO, SRAM_HI)) begin
        nxtState.target = TGT_SRAM;
        nxtState.offset = reqAddr - SRAM_LO;
      end else if (inRange(reqAddr, CORE_WIN_LO, CORE_WIN_HI)) begin
        // Open to every master
        nxtState.target = TGT_CORE_WIN;
        nxtState.offset = reqAddr - CORE_WIN_LO;
      end else if (inRange(reqAddr, WFL_A1_LO, WFL_A1_HI)) begin
        // Area one: ECC-generating write path
        nxtState.target = TGT_WFLASH;
        nxtState.offset = reqAddr - WFL_A1_LO;
        nxtState.eccGen = reqWrite;
        nxtState.error  = !reqWrite;
      end else if (inRange(reqAddr, WFL_A3_LO, WFL_A3_HI)) begin
        // Area three: raw write path
        nxtState.target = TGT_WFLASH;
        nxtState.offset = reqAddr - WFL_A3_LO;
        nxtState.eccGen = 1'b0;
        nxtState.error  = !reqWrite;
      end else if (inRange(reqAddr, WFL_A4_LO, WFL_A4_HI)) begin
        // Area four: read path
        nxtState.target = TGT_WFLASH;
        nxtState.offset = reqAddr - WFL_A4_LO;
        nxtState.error  = reqWrite;
      end else if (inRange(reqAddr, BURAM_LO, BURAM_HI)) begin
        nxtState.target = TGT_BURAM;
        nxtState.offset = reqAddr - BURAM_LO;
      end else if (inRange(reqAddr, XPERI_LO, XPERI_HI)) begin
        nxtState.target = TGT_EXTRA_PERI;
        nxtState.offset = reqAddr - XPERI_LO;
      end else if (inRange(reqAddr, PERI_LO, PERI_HI)) begin
        nxtState.target = TGT_PERI;
        nxtState.offset = reqAddr - PERI_LO;
      end else if (inRange(reqAddr, BOOT_LO, BOOT_HI)) begin
        // Boot ROM takes no writes
        nxtState.target = TGT_BOOTROM;
        nxtState.offset = reqAddr - BOOT_LO;
        nxtState.error  = reqWrite;
      end else if (inRange(reqAddr, ERROR_CONFIG_AREA_LO, ERROR_CONFIG_AREA_HI)) begin
        nxtState.target = TGT_ERROR_CONFIG_AREA;
        nxtState.offset = reqAddr - ERROR_CONFIG_AREA_LO;
      end else begin
        nxtState.error = 1'b1;
      end
      // Refused accesses select nothing and never write
      if (nxtState.error) begin
        nxtState.target = TGT_NONE;
        nxtState.offset = OFFSET_RST;
        nxtState.eccGen = 1'b0;
      end
      nxtState.wrEn = reqWrite && !nxtState.error;
    end
  end

  // Register the state; ce low freezes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stateFf <= '{valid: 1'b0, target: TGT_NONE, offset: OFFSET_RST,
                   eccGen: 1'b0, wrEn: 1'b0, error: 1'b0};
    end else if (ce) begin
      stateFf <= nxtState;
    end
  end

  // Requests are taken whenever the clock enable is high
  assign reqReady   = ce;
  assign respValid  = stateFf.valid;
  assign respTarget = stateFf.target;
  assign respOffset = stateFf.offset;
  assign respEccGen = stateFf.eccGen;
  assign respWrEn   = stateFf.wrEn;
  assign respError  = stateFf.error;

  // A request taken this cycle
  sequence s_take;
    reqValid && ce;
  endsequence
  // Answer on the following enabled edge
  sequence s_answer;
    respValid;
  endsequence

  property p_core_cpu_only;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 (!isCpu && reqAddr <= CORE_INT_HI) |=> s_answer ##0 respError && !respWrEn;
  endproperty
  a_core_cpu_only: assert property (p_core_cpu_only) else $error("core region open to master");

  property p_core_window;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 inRange(reqAddr, CORE_WIN_LO, CORE_WIN_HI)
      |=> respTarget == TGT_CORE_WIN && !respError
          && respOffset == $past(reqAddr) - CORE_WIN_LO;
  endproperty
  a_core_window: assert property (p_core_window) else $error("core window not served");

  property p_code_alias;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 isCpu && !reqWrite && inRange(reqAddr, CODE_AXI_LO, CODE_AXI_HI)
      |=> respTarget == TGT_PFLASH_CODE && respOffset == $past(reqAddr) - CODE_AXI_LO;
  endproperty
  a_code_alias: assert property (p_code_alias) else $error("code mirror offset wrong");

  property p_small_alias;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 isCpu && inRange(reqAddr, SMALL_TC_LO, SMALL_TC_HI) && !reqWrite
      |=> respTarget == TGT_PFLASH_SMALL && respOffset < SMALL_SPAN;
  endproperty
  a_small_alias: assert property (p_small_alias) else $error("small sector decode wrong");

  property p_wflash_offset;
    @(posedge clk) disable iff (!resetn)
      s_answer ##0 respTarget == TGT_WFLASH |-> respOffset < WFL_BYTES;
  endproperty
  a_wflash_offset: assert property (p_wflash_offset) else $error("work flash offset too big");

  property p_area1_ecc;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 reqWrite && inRange(reqAddr, WFL_A1_LO, WFL_A1_HI)
      |=> respEccGen && respWrEn && respTarget == TGT_WFLASH;
  endproperty
  a_area1_ecc: assert property (p_area1_ecc) else $error("area one write lacks ECC");

  property p_area3_raw;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 reqWrite && inRange(reqAddr, WFL_A3_LO, WFL_A3_HI)
      |=> !respEccGen && respWrEn && respOffset == $past(reqAddr) - WFL_A3_LO;
  endproperty
  a_area3_raw: assert property (p_area3_raw) else $error("area three write used ECC");

  property p_area4_read;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 inRange(reqAddr, WFL_A4_LO, WFL_A4_HI) |=> respError == $past(reqWrite);
  endproperty
  a_area4_read: assert property (p_area4_read) else $error("area four misused");

  property p_error_no_effect;
    @(posedge clk) disable iff (!resetn)
      respError |-> !respWrEn && !respEccGen && respTarget == TGT_NONE
                    && respOffset == OFFSET_RST;
  endproperty
  a_error_no_effect: assert property (p_error_no_effect) else $error("error touched memory");

  property p_reserved_error;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 inRange(reqAddr, 32'h0e40_0000, 32'h0e7f_ffff) |=> respError;
  endproperty
  a_reserved_error: assert property (p_reserved_error) else $error("reserved gap served");

  property p_mirror_size;
    @(posedge clk) disable iff (!resetn)
      s_take ##0 isCpu && !reqWrite && reqAddr == CODE_AXI_LO + CODE_BYTES - 32'h1
      |=> !respError ##0 respOffset == CODE_BYTES - 32'h1;
  endproperty
  a_mirror_size: assert property (p_mirror_size) else $error("mirror window end wrong");

endmodule : system_address_region_decoder

// >>> sim/bus_master_model.sv
/*
  Behavioural model of a system bus master (CPU complex or other master).
  Assumes the decoder takes a request at a rising clk edge with ce high.
*/
`timescale 1ns/100ps
module bus_master_model (
  input  wire logic        clk,
  input  wire logic        respValid,
  input  wire logic [31:0] respOffset,
  output      logic        reqValid,
  output      logic [31:0] reqAddr,
  output      logic        reqWrite,
  output      logic        isCpu
);
  // Idle bus at time zero
  initial begin
    reqValid = 1'b0;
    reqAddr  = 32'h0000_0000;
    reqWrite = 1'b0;
    isCpu    = 1'b0;
  end

  // One request, held for one edge; released lines show the inverse value
  task automatic request(input logic [31:0] addr, input logic wr, cpu, output logic seen);
    int n;
    seen = 1'b0;
    @(negedge clk);
    reqValid = 1'b1;
    reqAddr  = addr;
    reqWrite = wr;
    isCpu    = cpu;
    for (n = 0; n < 4 && !seen; n++) begin
      @(negedge clk);
      if (n == 0) begin
        reqValid = 1'b0;
        reqAddr  = ~addr;
        reqWrite = ~wr;
        isCpu    = ~cpu;
      end
      seen = (respValid === 1'b1);
    end
  endtask : request

  // Two CPU reads on consecutive edges; offsets captured in answer order
  task automatic burst(input logic [31:0] a1, a2, output logic [31:0] o1, o2);
    int n;
    int k;
    k  = 0;
    o1 = 32'hffff_ffff;
    o2 = 32'hffff_ffff;
    @(negedge clk);
    reqValid = 1'b1;
    reqAddr  = a1;
    reqWrite = 1'b0;
    isCpu    = 1'b1;
    for (n = 0; n < 5; n++) begin
      @(negedge clk);
      if (respValid === 1'b1) begin
        if (k == 0) o1 = respOffset;
        else o2 = respOffset;
        k++;
      end
      if (n == 0) reqAddr = a2;
      if (n == 1) begin
        reqValid = 1'b0;
        reqAddr  = ~a2;
      end
    end
  endtask : burst
endmodule : bus_master_model

// >>> sim/system_address_region_decoder_tb.sv
/*
  Self-checking bench for the system bus region decoder.
  Assumes region_map_pkg is compiled first and the bus master model is present.
*/
`timescale 1ns/100ps
module system_address_region_decoder_tb;
  import region_map_pkg::*;
  logic        clk;             // 100 MHz system clock
  logic        resetn;          // Active low reset
  logic        ce;              // Clock enable
  logic        reqValid;        // Request from master
  logic        reqReady;        // Handshake ready
  logic [31:0] reqAddr;         // Request address
  logic        reqWrite;        // Write request
  logic        isCpu;           // Request from CPU complex
  logic        respValid;       // Answer valid
  target_t     respTarget;      // Decoded target
  logic [31:0] respOffset;      // Offset in target
  logic        respEccGen;      // ECC generation
  logic        respWrEn;        // Write enable
  logic        respError;       // Bus error
  int          miscompares;     // Mismatch count
  int          samplesChecked;  // Comparison count

  system_address_region_decoder DUT (.clk(clk), .resetn(resetn), .ce(ce), .reqValid(reqValid),
    .reqReady(reqReady), .reqAddr(reqAddr), .reqWrite(reqWrite), .isCpu(isCpu),
    .respValid(respValid), .respTarget(respTarget), .respOffset(respOffset),
    .respEccGen(respEccGen), .respWrEn(respWrEn), .respError(respError));
  bus_master_model master (.clk(clk), .respValid(respValid), .respOffset(respOffset),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite), .isCpu(isCpu));

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("Checked %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Compare one value
  task automatic check(input string name, input logic [31:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Quiet outputs as after reset
  task automatic check_idle();
    check("respValid", {31'h0, respValid}, 32'h0);
    check("respTarget", {28'h0, respTarget}, {28'h0, TGT_NONE});
    check("respOffset", respOffset, 32'h0);
    check("respFlags", {29'h0, respEccGen, respWrEn, respError}, 32'h0);
    check("reqReady", {31'h0, reqReady}, {31'h0, ce});
  endtask : check_idle

  // One access and all of its answer fields
  task automatic access(input logic [31:0] addr, input logic wr, cpu, input target_t tgt,
                        input logic [31:0] off, input logic ecc, wen, err);
    logic seen;
    master.request(addr, wr, cpu, seen);
    if (!seen) begin
      miscompares++;
      complete_run();
    end else begin
      check("respTarget", {28'h0, respTarget}, {28'h0, tgt});
      check("respOffset", respOffset, off);
      check("respEccGen", {31'h0, respEccGen}, {31'h0, ecc});
      check("respWrEn", {31'h0, respWrEn}, {31'h0, wen});
      check("respError", {31'h0, respError}, {31'h0, err});
    end
  endtask : access

  // Refused access: error, no target, no write
  task automatic refused(input logic [31:0] addr, input logic wr, cpu);
    access(addr, wr, cpu, TGT_NONE, 32'h0, 1'b0, 1'b0, 1'b1);
  endtask : refused

  // Answer frozen while ce is low, then released
  task automatic ce_freeze();
    access(32'h0e00_0008, 1'b1, 1'b0, TGT_WFLASH, 32'h0000_0008, 1'b1, 1'b1, 1'b0);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check("respValid", {31'h0, respValid}, 32'h1);
    check("respOffset", respOffset, 32'h0000_0008);
    check("reqReady", {31'h0, reqReady}, 32'h0);
    ce = 1'b1;
    @(negedge clk);
    check("respValid", {31'h0, respValid}, 32'h0);
  endtask : ce_freeze

  // Back-to-back requests, one answer each in order
  task automatic back_to_back();
    logic [31:0] o1;
    logic [31:0] o2;
    master.burst(32'h0000_0100, 32'h0000_0200, o1, o2);
    check("firstOffset", o1, 32'h0000_0100);
    check("secondOffset", o2, 32'h0000_0200);
  endtask : back_to_back

  // Reset in mid-run clears the answer
  task automatic mid_reset();
    access(32'h0e21_0000, 1'b1, 1'b0, TGT_WFLASH, 32'h0001_0000, 1'b0, 1'b1, 1'b0);
    resetn = 1'b0;
    @(negedge clk);
    check_idle();
    resetn = 1'b1;
    @(negedge clk);
    check_idle();
  endtask : mid_reset

  // Memories and peripherals outside the core region, reserved gaps, and the last byte of the code mirror
  task automatic outer_targets();
    access(32'h0200_0010, 1'b0, 1'b0, TGT_SRAM, 32'h0000_0010, 1'b0, 1'b0, 1'b0);
    access(32'h0203_fffc, 1'b1, 1'b0, TGT_SRAM, 32'h0003_fffc, 1'b0, 1'b1, 1'b0);
    refused(32'h0204_0000, 1'b0, 1'b1);
    access(32'h0e80_0100, 1'b1, 1'b0, TGT_BURAM, 32'h0000_0100, 1'b0, 1'b1, 1'b0);
    refused(32'h0e40_0000, 1'b1, 1'b0);
    access(32'hb484_0400, 1'b1, 1'b0, TGT_EXTRA_PERI, 32'h0000_0400, 1'b0, 1'b1, 1'b0);
    access(32'hb000_0020, 1'b0, 1'b0, TGT_PERI, 32'h0000_0020, 1'b0, 1'b0, 1'b0);
    refused(32'hb800_0000, 1'b0, 1'b0);
    access(32'hffff_0010, 1'b0, 1'b1, TGT_BOOTROM, 32'h0000_0010, 1'b0, 1'b0, 1'b0);
    refused(32'hffff_0010, 1'b1, 1'b1);
    access(32'hffff_e004, 1'b1, 1'b0, TGT_ERROR_CONFIG_AREA, 32'h0000_0004, 1'b0, 1'b1, 1'b0);
    access(32'h01df_ffff, 1'b0, 1'b1, TGT_PFLASH_CODE, 32'h003f_ffff, 1'b0, 1'b0, 1'b0);
  endtask : outer_targets

  // Main sequence
  initial begin
    miscompares    = 0;
    samplesChecked = 0;
    resetn         = 1'b0;
    ce             = 1'b1;
    repeat (8) @(negedge clk);
    check_idle();
    resetn = 1'b1;
    access(32'h0000_1234, 1'b0, 1'b1, TGT_TIGHTLY_COUPLED_RAM, 32'h0000_1234, 1'b0, 1'b0, 1'b0);
    refused(32'h0000_1234, 1'b0, 1'b0);
    refused(32'h01a0_0010, 1'b0, 1'b0);
    access(32'h0280_002c, 1'b0, 1'b0, TGT_CORE_WIN, 32'h0000_002c, 1'b0, 1'b0, 1'b0);
    refused(32'h0280_0030, 1'b0, 1'b0);
    access(32'h00a0_0010, 1'b0, 1'b1, TGT_PFLASH_CODE, 32'h0000_0010, 1'b0, 1'b0, 1'b0);
    access(32'h01a0_0010, 1'b0, 1'b1, TGT_PFLASH_CODE, 32'h0000_0010, 1'b0, 1'b0, 1'b0);
    access(32'h009f_e004, 1'b0, 1'b1, TGT_PFLASH_SMALL, 32'h0000_e004, 1'b0, 1'b0, 1'b0);
    access(32'h019f_e004, 1'b0, 1'b1, TGT_PFLASH_SMALL, 32'h0000_e004, 1'b0, 1'b0, 1'b0);
    access(32'h01df_fffc, 1'b0, 1'b1, TGT_PFLASH_CODE, 32'h003f_fffc, 1'b0, 1'b0, 1'b0);
    refused(32'h01e0_0000, 1'b0, 1'b1);
    access(32'h0e00_0004, 1'b1, 1'b0, TGT_WFLASH, 32'h0000_0004, 1'b1, 1'b1, 1'b0);
    access(32'h0e01_bffc, 1'b1, 1'b0, TGT_WFLASH, 32'h0001_bffc, 1'b1, 1'b1, 1'b0);
    access(32'h0e21_bffc, 1'b1, 1'b0, TGT_WFLASH, 32'h0001_bffc, 1'b0, 1'b1, 1'b0);
    access(32'h0e30_0010, 1'b0, 1'b0, TGT_WFLASH, 32'h0000_0010, 1'b0, 1'b0, 1'b0);
    access(32'h0e31_bffc, 1'b0, 1'b1, TGT_WFLASH, 32'h0001_bffc, 1'b0, 1'b0, 1'b0);
    refused(32'h0e00_0000, 1'b0, 1'b0);
    refused(32'h0e30_0000, 1'b1, 1'b0);
    refused(32'h0e01_c000, 1'b1, 1'b0);
    refused(32'h0e31_c000, 1'b0, 1'b1);
    refused(32'h009f_0000, 1'b1, 1'b1);
    outer_targets();
    back_to_back();
    ce_freeze();
    mid_reset();
    complete_run();
  end
endmodule : system_address_region_decoder_tb
